/* File: pkg/sdram_ctl_regs.vh */
`ifndef SDRAM_CTL_REGS_VH
`define SDRAM_CTL_REGS_VH
// ==========================================================
// timing figures and counts (clock 100 MHz, 10 ns)
`define CLK_PERIOD_NS 10
`define T_RC_NS 67
`define T_RP_NS 19
`define T_RCD_NS 19
`define T_MRD_CK 2
`define T_RC_CK ((`T_RC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RP_CK ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RCD_CK ((`T_RCD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ==========================================================
// user request codes
`define REQ_NOP 4'h0
`define REQ_ACT 4'h1
`define REQ_RD 4'h2
`define REQ_WR 4'h3
`define REQ_PRE 4'h4
`define REQ_PREALL 4'h5
`define REQ_REF 4'h6
`define REQ_MRS 4'h7
`define REQ_BST 4'h8
`define REQ_PD 4'h9
`define REQ_SREF 4'ha
`define REQ_DPD 4'hb
`define REQ_WAKE 4'hc
`define REQ_SUSP 4'hd
// ==========================================================
// command pin codes {cs_b, ras_b, cas_b, we_b}
`define CMD_DESEL 4'h8
`define CMD_NOP 4'h7
`define CMD_ACT 4'h3
`define CMD_RD 4'h5
`define CMD_WR 4'h4
`define CMD_PRE 4'h2
`define CMD_REF 4'h1
`define CMD_MRS 4'h0
`define CMD_BST 4'h6
// ==========================================================
// address bit carrying the auto close option / all-banks flag
`define AUTO_CLOSE_BIT 10
`endif

/* File: rtl/sdram_cmd_ctl.v */
// Function
// [RULE_01] refresh, mode access or precharge-all: deselect or nop only
// [RULE_02] refreshing lasts from auto refresh until the refresh period passes
// [RULE_03] mode access lasts from mode set until its command period passes
// [RULE_04] precharging all lasts until the precharge period passes
// [RULE_05] never issue a state and command pair absent from the tables
// [RULE_06] multi-bank precharge only when every bank may be precharged
// [RULE_07] burst terminate acts on the latest burst of any bank
// [RULE_08] chip select high is deselect; all strobes high is nop
// [RULE_09] encodings: LHH activate, HLH read, HLL write, LHL precharge
// [RULE_10] an idle bank does not restrict commands to other banks
// [RULE_11] other banks may take commands their own state permits
// [RULE_12] refresh, self refresh, mode set only with all banks idle
// [RULE_13] burst terminate never aimed at another bank
// [RULE_14] write interrupting a read gets data mask to avoid collision
// [RULE_15] interrupted auto close burst starts precharge at interruption
// [RULE_16] auto close access: bank busy until precharge period, then idle
// [RULE_17] bank commands only with clock enable high on both edges
// [RULE_18] clock enable held low keeps low-power state, commands ignored
// [RULE_19] power down and self refresh exit only with deselect or nop
// [RULE_20] enable falling with nop enters precharge or active power down
// [RULE_21] enable falling: refresh-self refresh, stop-deep, burst-suspend
// [RULE_22] only deselect or nop during refresh period after self refresh
// [RULE_23] refresh period is at least 67 ns
// [RULE_24] delays convert to cycles rounding up
// [RULE_25] after deep power down, rerun the power-up command sequence
// [RULE_26] per-bank and global state machines with cycle counters
`timescale 1ns/1ps
`include "sdram_ctl_regs.vh"
`default_nettype none
module sdram_cmd_ctl #(
    parameter NUM_BANKS = 4,
    parameter BA_W = 2,
    parameter ADDR_W = 13,
    parameter BURST_LEN = 4
) (
    input wire clk,
    input wire rst_b,
    input wire req_valid,
    input wire [3:0] req_code,
    input wire [BA_W-1:0] req_bank,
    input wire [ADDR_W-1:0] req_addr,
    input wire req_auto_close,
    output wire req_ready,
    output reg req_error,
    output reg need_init,
    output reg cs_b,
    output reg ras_b,
    output reg cas_b,
    output reg we_b,
    output reg clk_en,
    output reg [BA_W-1:0] ba,
    output reg [ADDR_W-1:0] addr,
    output reg dqm
);
// ==========================================================
// bank and global states, one-hot
localparam [4:0] B_IDLE = 5'h01;
localparam [4:0] B_OPENING = 5'h02;
localparam [4:0] B_ACTIVE = 5'h04;
localparam [4:0] B_CLOSING = 5'h08;
localparam [4:0] B_BURST = 5'h10;
localparam [4:0] G_RUN = 5'h01;
localparam [4:0] G_BUSY = 5'h02;
localparam [4:0] G_PD = 5'h04;
localparam [4:0] G_SREF = 5'h08;
localparam [4:0] G_DPD = 5'h10;
localparam [7:0] RC_CK = `T_RC_CK;
localparam [7:0] RP_CK = `T_RP_CK;
localparam [7:0] RCD_CK = `T_RCD_CK;
localparam [7:0] MRD_CK = `T_MRD_CK;
localparam [7:0] BL_CK = BURST_LEN;

reg [4:0] bstate_reg [0:NUM_BANKS-1];
reg [7:0] bcnt_reg [0:NUM_BANKS-1];
reg [NUM_BANKS-1:0] bclose_reg;
reg bread_reg [0:NUM_BANKS-1];
reg [4:0] gstate_reg;
reg [7:0] gcnt_reg;
reg [BA_W-1:0] last_bank_reg;
reg burst_live_reg;
reg susp_reg;

// ==========================================================
// legality decode
wire [NUM_BANKS-1:0] b_idle;
wire [NUM_BANKS-1:0] b_act;
wire [NUM_BANKS-1:0] b_pre_ok;
genvar gi;
generate
    for (gi = 0; gi < NUM_BANKS; gi = gi + 1) begin : g_dec
        assign b_idle[gi] = bstate_reg[gi] == B_IDLE;
        assign b_act[gi] = bstate_reg[gi] == B_ACTIVE;
        // idle counts as precharge no-op, active or open burst may close
        assign b_pre_ok[gi] = b_idle[gi] | b_act[gi] |
            (bstate_reg[gi] == B_BURST && !bclose_reg[gi]); // [RULE_06]
    end
endgenerate
wire all_idle = &b_idle;
wire tb_state = bstate_reg[req_bank] == B_BURST;
wire tb_idle = b_idle[req_bank];
wire tb_act = b_act[req_bank];
wire tb_rw = tb_act | (tb_state & !bclose_reg[req_bank]);
reg legal;

// only table entries pass; others are refused [RULE_05] [RULE_10] [RULE_11]
always @* begin
    legal = 1'b0;
    if (gstate_reg == G_RUN && !susp_reg) begin // [RULE_17] [RULE_01]
        case (req_code)
            `REQ_NOP: legal = 1'b1;
            `REQ_ACT: legal = tb_idle;
            `REQ_RD: legal = tb_rw;
            `REQ_WR: legal = tb_rw;
            `REQ_PRE: legal = b_pre_ok[req_bank];
            `REQ_PREALL: legal = &b_pre_ok; // [RULE_06]
            `REQ_REF: legal = all_idle; // [RULE_12]
            `REQ_MRS: legal = all_idle; // [RULE_12]
            `REQ_SREF: legal = all_idle; // [RULE_12]
            `REQ_DPD: legal = all_idle;
            `REQ_PD: legal = !burst_live_reg;
            `REQ_SUSP: legal = burst_live_reg; // [RULE_21]
            // stop only the latest burst, its own bank [RULE_07] [RULE_13]
            `REQ_BST: legal = burst_live_reg && req_bank == last_bank_reg &&
                !bclose_reg[req_bank];
            default: legal = 1'b0;
        endcase
        // power-up sequence only until mode set [RULE_25]
        if (need_init && req_code != `REQ_NOP && req_code != `REQ_PREALL &&
            req_code != `REQ_REF && req_code != `REQ_MRS)
            legal = 1'b0;
    end else if (gstate_reg != G_BUSY) begin // suspended or low power [RULE_19]
        legal = req_code == `REQ_WAKE;
    end
end

// ready while no global wait runs; low-power states take wake only
assign req_ready = gstate_reg != G_BUSY;
wire take = req_valid & req_ready & legal;
wire is_rw = req_code == `REQ_RD || req_code == `REQ_WR;

// ==========================================================
// pin driver: command, clock enable, mask
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        {cs_b, ras_b, cas_b, we_b} <= `CMD_DESEL;
        clk_en <= 1'b1;
        ba <= {BA_W{1'b0}};
        addr <= {ADDR_W{1'b0}};
        dqm <= 1'b0;
        req_error <= 1'b0;
    end else begin
        {cs_b, ras_b, cas_b, we_b} <= `CMD_NOP; // [RULE_08] [RULE_22]
        req_error <= req_valid & req_ready & !legal;
        dqm <= 1'b0;
        if (take) begin
            ba <= req_bank;
            addr <= req_addr;
            case (req_code)
                `REQ_ACT: {cs_b, ras_b, cas_b, we_b} <= `CMD_ACT; // [RULE_09]
                `REQ_RD: begin
                    {cs_b, ras_b, cas_b, we_b} <= `CMD_RD; // [RULE_09]
                    addr[`AUTO_CLOSE_BIT] <= req_auto_close;
                end
                `REQ_WR: begin
                    {cs_b, ras_b, cas_b, we_b} <= `CMD_WR; // [RULE_09]
                    addr[`AUTO_CLOSE_BIT] <= req_auto_close;
                    // mask read data still draining [RULE_14]
                    dqm <= burst_live_reg & bread_reg[last_bank_reg];
                end
                `REQ_PRE: begin
                    {cs_b, ras_b, cas_b, we_b} <= `CMD_PRE; // [RULE_09]
                    addr[`AUTO_CLOSE_BIT] <= 1'b0;
                end
                `REQ_PREALL: begin
                    {cs_b, ras_b, cas_b, we_b} <= `CMD_PRE;
                    addr[`AUTO_CLOSE_BIT] <= 1'b1;
                end
                `REQ_REF: {cs_b, ras_b, cas_b, we_b} <= `CMD_REF;
                `REQ_MRS: {cs_b, ras_b, cas_b, we_b} <= `CMD_MRS;
                `REQ_BST: {cs_b, ras_b, cas_b, we_b} <= `CMD_BST;
                // falling enable with nop [RULE_20]
                `REQ_PD: clk_en <= 1'b0;
                `REQ_SUSP: clk_en <= 1'b0;
                `REQ_SREF: begin
                    {cs_b, ras_b, cas_b, we_b} <= `CMD_REF; // [RULE_21]
                    clk_en <= 1'b0;
                end
                `REQ_DPD: begin
                    {cs_b, ras_b, cas_b, we_b} <= `CMD_BST; // [RULE_21]
                    clk_en <= 1'b0;
                end
                `REQ_WAKE: clk_en <= 1'b1; // nop with rising enable [RULE_19]
                default: {cs_b, ras_b, cas_b, we_b} <= `CMD_NOP;
            endcase
        end
    end
end

// ==========================================================
// global state: refresh, mode access, precharge all, low power
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        gstate_reg <= G_RUN;
        gcnt_reg <= 8'h00;
        susp_reg <= 1'b0;
        need_init <= 1'b0;
    end else begin
        case (gstate_reg)
            G_RUN: begin
                if (take) begin
                    case (req_code)
                        `REQ_REF: begin // [RULE_02] [RULE_23] [RULE_24]
                            gstate_reg <= G_BUSY;
                            gcnt_reg <= RC_CK - 8'h01;
                        end
                        `REQ_MRS: begin // [RULE_03]
                            gstate_reg <= G_BUSY;
                            gcnt_reg <= MRD_CK - 8'h01;
                            need_init <= 1'b0; // init sequence done [RULE_25]
                        end
                        `REQ_PREALL: begin // [RULE_04]
                            gstate_reg <= G_BUSY;
                            gcnt_reg <= RP_CK - 8'h01;
                        end
                        `REQ_PD: gstate_reg <= G_PD;
                        `REQ_SREF: gstate_reg <= G_SREF;
                        `REQ_DPD: gstate_reg <= G_DPD;
                        `REQ_SUSP: susp_reg <= 1'b1;
                        `REQ_WAKE: susp_reg <= 1'b0;
                        default: gstate_reg <= G_RUN;
                    endcase
                end
            end
            G_BUSY: begin // only nop goes out meanwhile [RULE_01]
                if (gcnt_reg == 8'h00)
                    gstate_reg <= G_RUN;
                else
                    gcnt_reg <= gcnt_reg - 8'h01;
            end
            // enable held low: state kept [RULE_18]
            G_PD: if (take) gstate_reg <= G_RUN;
            G_SREF: begin
                if (take) begin // nop for refresh period on exit [RULE_22]
                    gstate_reg <= G_BUSY;
                    gcnt_reg <= RC_CK - 8'h01; // [RULE_22] [RULE_23]
                end
            end
            G_DPD: begin
                if (take) begin
                    gstate_reg <= G_RUN;
                    need_init <= 1'b1; // [RULE_25]
                end
            end
            default: gstate_reg <= G_RUN;
        endcase
    end
end

// ==========================================================
// burst tracker for terminate, suspend and masking
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        burst_live_reg <= 1'b0;
        last_bank_reg <= {BA_W{1'b0}};
    end else if (take && is_rw) begin
        burst_live_reg <= 1'b1;
        last_bank_reg <= req_bank; // [RULE_07]
    end else if (take && (req_code == `REQ_BST ||
        (req_code == `REQ_PRE && req_bank == last_bank_reg) ||
        req_code == `REQ_PREALL)) begin
        burst_live_reg <= 1'b0;
    end else if (!susp_reg && burst_live_reg &&
        bstate_reg[last_bank_reg] != B_BURST) begin
        burst_live_reg <= 1'b0;
    end
end

// ==========================================================
// per-bank state machines with counters [RULE_26]
generate
    for (gi = 0; gi < NUM_BANKS; gi = gi + 1) begin : g_bank
        wire hit = take && req_bank == gi;
        wire pre_hit = take && ((req_code == `REQ_PRE && req_bank == gi) ||
            req_code == `REQ_PREALL);
        // another bank's access cuts this auto close burst [RULE_15]
        wire cut = take && is_rw && req_bank != gi;
        always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                bstate_reg[gi] <= B_IDLE;
                bcnt_reg[gi] <= 8'h00;
                bclose_reg[gi] <= 1'b0;
                bread_reg[gi] <= 1'b0;
            end else if (!susp_reg) begin
                case (bstate_reg[gi])
                    B_IDLE: begin
                        if (hit && req_code == `REQ_ACT) begin
                            bstate_reg[gi] <= B_OPENING;
                            bcnt_reg[gi] <= RCD_CK - 8'h01;
                        end
                    end
                    B_OPENING, B_CLOSING: begin
                        if (bcnt_reg[gi] == 8'h00)
                            bstate_reg[gi] <= bstate_reg[gi] == B_OPENING ?
                                B_ACTIVE : B_IDLE;
                        else
                            bcnt_reg[gi] <= bcnt_reg[gi] - 8'h01;
                    end
                    B_ACTIVE, B_BURST: begin
                        if (pre_hit || (bclose_reg[gi] && cut)) begin
                            bstate_reg[gi] <= B_CLOSING;
                            bcnt_reg[gi] <= RP_CK - 8'h01;
                            bclose_reg[gi] <= 1'b0;
                        end else if (hit && is_rw) begin
                            bstate_reg[gi] <= B_BURST;
                            bcnt_reg[gi] <= BL_CK - 8'h01;
                            bclose_reg[gi] <= req_auto_close; // [RULE_16]
                            bread_reg[gi] <= req_code == `REQ_RD;
                        end else if (hit && req_code == `REQ_BST) begin
                            bstate_reg[gi] <= B_ACTIVE;
                        end else if (bstate_reg[gi] == B_BURST) begin
                            if (bcnt_reg[gi] != 8'h00) begin
                                bcnt_reg[gi] <= bcnt_reg[gi] - 8'h01;
                            end else if (bclose_reg[gi]) begin
                                bstate_reg[gi] <= B_CLOSING; // [RULE_16]
                                bcnt_reg[gi] <= RP_CK - 8'h01;
                                bclose_reg[gi] <= 1'b0;
                            end else begin
                                bstate_reg[gi] <= B_ACTIVE;
                            end
                        end
                    end
                    default: bstate_reg[gi] <= B_IDLE;
                endcase
            end
        end
    end
endgenerate
endmodule // sdram_cmd_ctl
`default_nettype wire

/* File: tb/sdram_cmd_ctl_sva.sv */
`timescale 1ns/1ps
`include "sdram_ctl_regs.vh"
`default_nettype none
// ==========================================================
// pin-level checks of the controller
module sdram_cmd_ctl_sva #(
    parameter ADDR_W = 13
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_ready,
    input wire logic req_error,
    input wire logic need_init,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic dqm
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [3:0] cmd;
    logic quiet;
    logic run;
    logic sref_reg;
    // pin decode
    assign cmd = {cs_b, ras_b, cas_b, we_b};
    assign quiet = cs_b || (cmd == `CMD_NOP);
    assign run = cmd inside {`CMD_ACT, `CMD_RD, `CMD_WR};
    // self refresh entered and not yet left
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) sref_reg <= 1'b0;
        else sref_reg <= !clk_en && (sref_reg || cmd == `CMD_REF);
    end
    a_ref_quiet: assert property (
        cmd == `CMD_REF && clk_en |=> quiet [*6])
        else $error("command inside refresh period");
    a_ref_ready: assert property (
        cmd == `CMD_REF && clk_en |-> !req_ready [*6] ##[1:4] req_ready)
        else $error("ready wrong around refresh");
    a_mrs_quiet: assert property (cmd == `CMD_MRS |=> quiet)
        else $error("command inside mode set period");
    a_preall_quiet: assert property (
        cmd == `CMD_PRE && addr[`AUTO_CLOSE_BIT] |=> quiet)
        else $error("command inside precharge all period");
    a_error_no_cmd: assert property (req_error |-> quiet)
        else $error("refused request still issued");
    a_dqm_with_wr: assert property (
        dqm |-> cmd == `CMD_WR ##1 !dqm)
        else $error("mask pulse without write");
    a_cke_both_high: assert property (
        run || cmd == `CMD_MRS |-> clk_en && $past(clk_en))
        else $error("bank command without clock enable");
    a_wake_quiet: assert property ($rose(clk_en) |-> quiet)
        else $error("clock enable rose with a command");
    a_sref_exit: assert property (
        $rose(clk_en) && sref_reg |-> quiet [*7])
        else $error("command during self refresh exit");
    a_init_first: assert property (need_init |-> !run)
        else $error("access before init sequence");
    c_ref: cover property (cmd == `CMD_REF && clk_en);
    c_sref: cover property ($rose(clk_en) && sref_reg);
    c_dqm: cover property (dqm);
    c_err: cover property (req_error);
endmodule // sdram_cmd_ctl_sva

bind sdram_cmd_ctl sdram_cmd_ctl_sva #(.ADDR_W(ADDR_W)) sdram_cmd_ctl_sva_i (
    .clk(clk), .rst_b(rst_b), .req_ready(req_ready), .req_error(req_error),
    .need_init(need_init), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
    .we_b(we_b), .clk_en(clk_en), .addr(addr), .dqm(dqm));
`default_nettype wire

/* File: tb/sdram_dev_model.sv */
`timescale 1ns/1ps
`include "sdram_ctl_regs.vh"
`default_nettype none
// ==========================================================
// memory device watching the pins, counting misuse
module sdram_dev_model (
    input wire logic clk,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic clk_en,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    output logic [7:0] viol
);
    logic [7:0] viol_reg = 8'h00;
    logic [3:0] open_reg = 4'h0;
    logic [3:0] busy_reg = 4'h0;
    logic cke_reg = 1'b1;
    logic sref_reg = 1'b0;
    logic pd_reg = 1'b0;
    logic [3:0] cmd;
    logic quiet;
    // pin decode
    assign cmd = {cs_b, ras_b, cas_b, we_b};
    assign quiet = cs_b || (cmd == `CMD_NOP);
    assign viol = viol_reg;
    // state advanced at each rising edge
    always @(posedge clk) begin
        cke_reg <= clk_en;
        if (busy_reg != 4'h0)
            busy_reg <= busy_reg - 4'h1;
        if (!cke_reg && !clk_en) begin
            pd_reg <= pd_reg; // pins ignored
        end else if (!cke_reg) begin
            if ((sref_reg || pd_reg) && !quiet)
                viol_reg <= viol_reg + 8'h01;
            if (sref_reg)
                busy_reg <= 4'(`T_RC_CK - 1);
            sref_reg <= 1'b0;
            pd_reg <= 1'b0;
        end else if (!clk_en) begin
            sref_reg <= cmd == `CMD_REF;
            pd_reg <= quiet;
        end else if (!quiet) begin
            if (busy_reg != 4'h0)
                viol_reg <= viol_reg + 8'h01;
            case (cmd)
                `CMD_ACT: open_reg[ba] <= 1'b1;
                `CMD_PRE: begin
                    if (addr[`AUTO_CLOSE_BIT]) begin
                        open_reg <= 4'h0;
                        busy_reg <= 4'(`T_RP_CK - 1);
                    end else begin
                        open_reg[ba] <= 1'b0;
                    end
                end
                `CMD_RD, `CMD_WR: begin
                    if (addr[`AUTO_CLOSE_BIT])
                        open_reg[ba] <= 1'b0;
                end
                `CMD_REF, `CMD_MRS: begin
                    if (open_reg != 4'h0)
                        viol_reg <= viol_reg + 8'h01;
                    if (cmd == `CMD_REF)
                        busy_reg <= 4'(`T_RC_CK - 1);
                    else
                        busy_reg <= 4'(`T_MRD_CK - 1);
                end
                default: busy_reg <= busy_reg; // burst stop
            endcase
        end
    end
endmodule // sdram_dev_model
`default_nettype wire

/* File: tb/sdram_cmd_ctl_test.sv */
`timescale 1ns/1ps
`include "sdram_ctl_regs.vh"
`default_nettype none
// ==========================================================
// directed scenarios for the command controller
module sdram_cmd_ctl_test;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_auto_close = 1'b0;
    logic [3:0] req_code = 4'h0;
    logic [1:0] req_bank = 2'h0;
    logic [12:0] req_addr = 13'h0000;
    logic [3:0] pins;
    logic err;
    int k;
    wire req_ready, req_error, need_init, cs_b, ras_b, cas_b, we_b;
    wire clk_en, dqm;
    wire [1:0] ba;
    wire [12:0] addr;
    wire [7:0] viol;
    int bad_count = 0;
    int n_tests = 0;
    // 100 MHz clock
    always #5 clk = ~clk;
    sdram_cmd_ctl sdram_cmd_ctl_i (.clk(clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_code(req_code), .req_bank(req_bank),
        .req_addr(req_addr), .req_auto_close(req_auto_close),
        .req_ready(req_ready), .req_error(req_error), .need_init(need_init),
        .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
        .clk_en(clk_en), .ba(ba), .addr(addr), .dqm(dqm));
    sdram_dev_model sdram_dev_model_i (.clk(clk), .cs_b(cs_b), .ras_b(ras_b),
        .cas_b(cas_b), .we_b(we_b), .clk_en(clk_en), .ba(ba), .addr(addr),
        .viol(viol));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bchk(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task pchk(input logic [3:0] exp);
        chk({12'h000, pins}, {12'h000, exp});
    endtask
    task tally_and_finish;
        $display("mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task idle(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    // request held until ready is seen at an edge
    task issue(input logic [3:0] c, input logic [1:0] b,
               input logic [12:0] a, input logic ac);
        logic took;
        int i;
        idle(1);
        took = 1'b0;
        i = 0;
        req_valid = 1'b1;
        req_code = c;
        req_bank = b;
        req_addr = a;
        req_auto_close = ac;
        while (!took && i < 40) begin
            #8;
            took = (req_ready === 1'b1);
            @(posedge clk);
            #1;
            i++;
        end
        req_valid = 1'b0;
        pins = {cs_b, ras_b, cas_b, we_b};
        err = req_error;
        if (!took) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task lowcnt;
        k = 0;
        while (req_ready !== 1'b1 && k < 20) begin
            idle(1);
            k++;
        end
        if (req_ready !== 1'b1) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task t_banks;
        issue(`REQ_ACT, 2'h0, 13'h0123, 1'b0);
        pchk(`CMD_ACT);
        chk({1'b0, ba, addr}, 16'h0123);
        issue(`REQ_ACT, 2'h2, 13'h0045, 1'b0);
        pchk(`CMD_ACT);
        idle(2);
        issue(`REQ_RD, 2'h0, 13'h0010, 1'b0);
        pchk(`CMD_RD);
        issue(`REQ_WR, 2'h2, 13'h0020, 1'b0);
        pchk(`CMD_WR);
        bchk(dqm, 1'b1);
        issue(`REQ_BST, 2'h2, 13'h0000, 1'b0);
        pchk(`CMD_BST);
        issue(`REQ_REF, 2'h0, 13'h0000, 1'b0);
        bchk(err, 1'b1);
        pchk(`CMD_NOP);
        issue(`REQ_PRE, 2'h0, 13'h0000, 1'b0);
        pchk(`CMD_PRE);
        bchk(addr[`AUTO_CLOSE_BIT], 1'b0);
        idle(2);
        issue(`REQ_RD, 2'h0, 13'h0010, 1'b0);
        bchk(err, 1'b1);
        issue(`REQ_PREALL, 2'h0, 13'h0000, 1'b0);
        pchk(`CMD_PRE);
        bchk(addr[`AUTO_CLOSE_BIT], 1'b1);
        lowcnt();
        chk(16'(k), 16'(`T_RP_CK));
    endtask
    task t_refresh;
        issue(`REQ_REF, 2'h0, 13'h0000, 1'b0);
        pchk(`CMD_REF);
        lowcnt();
        chk(16'(k), 16'(`T_RC_CK));
        issue(`REQ_ACT, 2'h1, 13'h0077, 1'b0);
        bchk(err, 1'b0);
        idle(2);
        issue(`REQ_RD, 2'h1, 13'h0008, 1'b1);
        pchk(`CMD_RD);
        bchk(addr[`AUTO_CLOSE_BIT], 1'b1);
        idle(12);
        issue(`REQ_ACT, 2'h1, 13'h0077, 1'b0);
        pchk(`CMD_ACT);
        idle(2);
        issue(`REQ_PREALL, 2'h0, 13'h0000, 1'b0);
        pchk(`CMD_PRE);
        issue(`REQ_MRS, 2'h0, 13'h0033, 1'b0);
        pchk(`CMD_MRS);
        lowcnt();
        chk(16'(k), 16'(`T_MRD_CK));
    endtask
    task t_power;
        issue(`REQ_PD, 2'h0, 13'h0000, 1'b0);
        bchk(clk_en, 1'b0);
        idle(4);
        bchk(clk_en, 1'b0);
        issue(`REQ_WAKE, 2'h0, 13'h0000, 1'b0);
        pchk(`CMD_NOP);
        issue(`REQ_SREF, 2'h0, 13'h0000, 1'b0);
        pchk(`CMD_REF);
        bchk(clk_en, 1'b0);
        idle(3);
        issue(`REQ_WAKE, 2'h0, 13'h0000, 1'b0);
        bchk(clk_en, 1'b1);
        lowcnt();
        chk(16'(k), 16'(`T_RC_CK));
        issue(`REQ_DPD, 2'h0, 13'h0000, 1'b0);
        pchk(`CMD_BST);
        issue(`REQ_WAKE, 2'h0, 13'h0000, 1'b0);
        bchk(need_init, 1'b1);
        issue(`REQ_ACT, 2'h0, 13'h0001, 1'b0);
        bchk(err, 1'b1);
        issue(`REQ_PREALL, 2'h0, 13'h0000, 1'b0);
        issue(`REQ_REF, 2'h0, 13'h0000, 1'b0);
        issue(`REQ_MRS, 2'h0, 13'h0033, 1'b0);
        bchk(need_init, 1'b0);
        // clock suspend holds a burst, which stays stoppable after wake
        issue(`REQ_ACT, 2'h3, 13'h0005, 1'b0);
        idle(2);
        issue(`REQ_RD, 2'h3, 13'h0004, 1'b0);
        issue(`REQ_SUSP, 2'h3, 13'h0000, 1'b0);
        bchk(clk_en, 1'b0);
        idle(3);
        issue(`REQ_WAKE, 2'h0, 13'h0000, 1'b0);
        bchk(clk_en, 1'b1);
        issue(`REQ_BST, 2'h3, 13'h0000, 1'b0);
        pchk(`CMD_BST);
    endtask
    // reset, scenarios, verdict
    initial begin
        repeat (2) @(posedge clk);
        #1;
        bchk(cs_b, 1'b1);
        rst_b = 1'b1;
        t_banks();
        t_refresh();
        t_power();
        chk({8'h00, viol}, 16'h0000);
        tally_and_finish();
    end
    // hang guard
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
endmodule // sdram_cmd_ctl_test
`default_nettype wire
